// ==== hdl/radio_cfg_pkg.sv ====
/*
 * Shared constants, types and helpers for the radio module's
 * configuration port: the device end and the host end both use it.
 * Assumes a single 250 MHz clock on both ends.
 */
package radio_cfg_pkg;

	// ************************************************
	// Timing
	// ************************************************
	localparam int unsigned CLK_HZ      = 250_000_000;
	localparam int unsigned NORMAL_MS   = 50;
	localparam int unsigned SETTING_MS  = 1;
	localparam int unsigned REPLY_MS    = 200;
	localparam int unsigned APPLY_MS    = 10;
	localparam int unsigned NORMAL_CYC  = CLK_HZ / 1000 * NORMAL_MS;
	localparam int unsigned SETTING_CYC = CLK_HZ / 1000 * SETTING_MS;
	localparam int unsigned REPLY_CYC   = CLK_HZ / 1000 * REPLY_MS;
	localparam int unsigned APPLY_CYC   = CLK_HZ / 1000 * APPLY_MS;
	localparam int unsigned SETUP_BAUD  = 9600;
	localparam int unsigned TW          = 26;

	// ************************************************
	// Characters and fields
	// ************************************************
	localparam logic [7:0]  SP       = 8'h20;
	localparam logic [7:0]  CR       = 8'h0D;
	localparam logic [7:0]  LF       = 8'h0A;
	localparam logic [7:0]  DIG_LO   = 8'h30;
	localparam logic [3:0]  DIG_HI   = 4'h3;
	localparam logic [31:0] TAG_REPL = 32'h50415241;
	localparam logic [15:0] KEY_WR   = 16'h5752;
	localparam logic [31:0] CMD_RD   = 32'h52440D0A;
	localparam logic [47:0] FREQ_MIN = 48'h343138303030;
	localparam logic [47:0] FREQ_MAX = 48'h343535303030;
	localparam logic [23:0] BCD_MIN  = 24'h418000;
	localparam logic [23:0] BCD_MAX  = 24'h455000;
	localparam logic [3:0]  UB_SETUP = 4'h3;
	localparam logic [4:0]  RD_LEN   = 5'h04;
	localparam logic [4:0]  WR_LEN   = 5'h13;
	localparam logic [4:0]  REP_LEN  = 5'h15;

	// Parameter set, every field held as ASCII.
	typedef struct packed {
		logic [47:0] freq;
		logic [7:0]  rf;
		logic [7:0]  pw;
		logic [7:0]  ub;
		logic [7:0]  pa;
	} prm_t;

	localparam prm_t PRM_RST = '{48'h343334303030, 8'h33, 8'h39,
		8'h33, 8'h30};

	// Host register byte addresses.
	localparam logic [4:0] A_CTRL   = 5'h00;
	localparam logic [4:0] A_FREQ   = 5'h04;
	localparam logic [4:0] A_CODES  = 5'h08;
	localparam logic [4:0] A_STAT   = 5'h0C;
	localparam logic [4:0] A_RFREQ  = 5'h10;
	localparam logic [4:0] A_RCODES = 5'h14;

	// Device phases.
	typedef enum logic [2:0] {
		sleep_phase   = 3'b000,
		normal_phase  = 3'b001,
		enter_phase   = 3'b010,
		setting_phase = 3'b011,
		reply_phase   = 3'b100,
		apply_phase   = 3'b101,
		resume_phase  = 3'b110
	} phase_t;

	// True when an ASCII character lies between two digits.
	function automatic logic in_rng(input logic [7:0] c,
		input logic [3:0] lo, input logic [3:0] hi);
		in_rng = (c >= {DIG_HI, lo}) && (c <= {DIG_HI, hi});
	endfunction

	// Fields of a command or reply after its keyword.
	function automatic logic [127:0] body_of(input prm_t p);
		body_of = {p.freq, SP, p.rf, SP, p.pw, SP, p.ub, SP, p.pa,
			CR, LF};
	endfunction

endpackage

// ==== hdl/radio_link_if.sv ====
/*
 * The pins between the host terminal and the radio module.
 * Assumes both ends share one clock; the testbench joins the ends.
 */
`timescale 1ns/1ps
`default_nettype none
interface radio_link_if;
	logic set_pin;   // Low selects setting, high normal work.
	logic en_pin;    // Low puts the module to sleep.
	logic down_line; // Serial data from host to module.
	logic up_line;   // Serial data from module to host.

	modport dev_end (
		input  set_pin,
		input  en_pin,
		input  down_line,
		output up_line
	);
	modport host_end (
		output set_pin,
		output en_pin,
		output down_line,
		input  up_line
	);
endinterface
`default_nettype wire

// ==== hdl/radio_cfg_dev.sv ====
/*
 * Radio module end: setting-mode command interpreter, serial port with
 * selectable rate and parity, and the transparent serial/radio relay.
 * Assumes the radio itself sits behind the air_* byte handshakes.
 */
// Decided for this implementation: the plain strobed port and the placing of the registers.
// Notes on behaviour
// RL1: Normal work 50 ms after select rises.
// RL2: Select low: 9600 no parity, setting in 1 ms.
// RL3: Valid command answered within 200 ms.
// RL4: New parameters take effect 10 ms after rise.
// RL5: Host sends one command per setting entry.
// RL6: Uppercase ASCII only; lowercase keywords rejected.
// RL7: Fields split by one space, line ends CRLF.
// RL8: Read returns tag and all five fields.
// RL9: Write carries five fields, echoed after tag.
// RL10: Frequency is six decimal digits in kHz.
// RL11: Frequency accepted only from 418 to 455 MHz.
// RL12: Radio rate digit 1 to 4.
// RL13: Power digit 0 to 9.
// RL14: Serial rate digit 0 to 6.
// RL15: Parity digit 0 none, 1 even, 2 odd.
// RL16: Enable low sleeps, high or open runs.
// RL17: Normal mode relays data half duplex.
// RL18: At least 256 bytes buffered toward radio.
// RL19: Normal frames 8 data, 1 stop, parity.
// RL20: Bad command keeps parameters, sends no reply.
`timescale 1ns/1ps
`default_nettype none
module radio_cfg_dev import radio_cfg_pkg::*; #(
	parameter int unsigned clk_hz      = CLK_HZ,
	parameter int unsigned normal_cyc  = NORMAL_CYC,
	parameter int unsigned setting_cyc = SETTING_CYC,
	parameter int unsigned apply_cyc   = APPLY_CYC,
	parameter int unsigned fifo_aw     = 8
) (
	// Clock and reset.
	input  wire logic         clk_in,
	input  wire logic         rst_in,
	// Pins toward the host.
	radio_link_if.dev_end     link,
	// Bytes toward the radio.
	output var  logic [7:0]   air_tx_data_out,
	output var  logic         air_tx_valid_out,
	input  wire logic         air_tx_ready_in,
	// Bytes from the radio.
	input  wire logic [7:0]   air_rx_data_in,
	input  wire logic         air_rx_valid_in,
	output var  logic         air_rx_ready_out,
	// Status.
	output var  phase_t       phase_out,
	output var  prm_t         params_out
);
	localparam int unsigned PW = fifo_aw + 1;

	typedef struct packed {
		phase_t          md;
		logic [2:0]      ss, rs, es;
		logic            sf, rf, ef;
		logic [TW-1:0]   tm;
		logic            rb;
		logic [17:0]     rc;
		logic [3:0]      ri;
		logic [10:0]     rsh;
		logic            tb;
		logic [17:0]     tc;
		logic [3:0]      ti;
		logic [10:0]     tsh;
		logic            txd;
		logic [PW-1:0]   wp, rp;
		logic            av;
		logic [7:0]      ad;
		logic            ar;
		logic [151:0]    cb;
		logic [4:0]      cn;
		logic [167:0]    rbuf;
		logic [4:0]      rn;
		prm_t            act, pen;
	} dev_t;

	dev_t st_q, st_d;
	logic [7:0] mem [0:(1<<fifo_aw)-1];
	logic       wr_en, got, fall, rise, norm, txl, wr_ok;
	logic [7:0] gb, txb;
	logic [17:0] dv;
	logic [1:0]  np;
	logic [3:0]  nbits;
	prm_t        nw;

	// Bit period in clocks for each serial rate code.
	function automatic logic [17:0] div_of(input logic [3:0] c);
		case (c)
			4'h0:    div_of = 18'(clk_hz / 1200);
			4'h1:    div_of = 18'(clk_hz / 2400);
			4'h2:    div_of = 18'(clk_hz / 4800);
			4'h4:    div_of = 18'(clk_hz / 19200);
			4'h5:    div_of = 18'(clk_hz / 38400);
			4'h6:    div_of = 18'(clk_hz / 57600);
			default: div_of = 18'(clk_hz / SETUP_BAUD);
		endcase
	endfunction

	// ************************************************
	// Next-state logic
	// ************************************************
	always_comb begin
		st_d = st_q;
		wr_en = 1'b0;
		got = 1'b0;
		gb = st_q.rsh[8:1];
		txl = 1'b0;
		txb = 8'h00;
		// Pin synchronisers: a change counts when stages two and three agree.
		st_d.ss = {st_q.ss[1:0], link.set_pin};
		st_d.rs = {st_q.rs[1:0], link.down_line};
		st_d.es = {st_q.es[1:0], link.en_pin};
		if (st_q.ss[1] == st_q.ss[2]) st_d.sf = st_q.ss[2];
		if (st_q.rs[1] == st_q.rs[2]) st_d.rf = st_q.rs[2];
		if (st_q.es[1] == st_q.es[2]) st_d.ef = st_q.es[2];
		fall = st_q.sf & ~st_d.sf;
		rise = ~st_q.sf & st_d.sf;
		norm = (st_q.md == normal_phase);
		// Setting mode forces 9600 with no parity.
		dv = norm ? div_of(st_q.act.ub[3:0]) : div_of(UB_SETUP); // RL2
		np = norm ? st_q.act.pa[1:0] : 2'h0; // RL15
		nbits = (np != 2'h0) ? 4'hA : 4'h9; // RL19

		// Receiver: bit 0 start, 1..8 data, then parity and stop.
		if (st_q.rb) begin
			if (st_q.rc != 18'h0) begin
				st_d.rc = st_q.rc - 18'h1;
			end else begin
				st_d.rc = dv - 18'h1;
				st_d.rsh[st_q.ri] = st_q.rf;
				st_d.ri = st_q.ri + 4'h1;
				if (st_q.ri == 4'h0 && st_q.rf) begin
					st_d.rb = 1'b0;
				end else if (st_q.ri == nbits) begin
					st_d.rb = 1'b0;
					got = st_q.rf && (np == 2'h0 ||
						(^st_q.rsh[9:1]) == np[1]); // RL19
				end
			end
		end else if (!st_q.rf) begin
			st_d.rb = 1'b1;
			st_d.ri = 4'h0;
			st_d.rc = {1'b0, dv[17:1]};
		end

		// Transmitter shifts one bit per period, stop bit last.
		if (st_q.tb) begin
			if (st_q.tc != 18'h0) begin
				st_d.tc = st_q.tc - 18'h1;
			end else begin
				st_d.tc = dv - 18'h1;
				st_d.tsh = {1'b1, st_q.tsh[10:1]};
				st_d.ti = st_q.ti - 4'h1;
				if (st_q.ti == 4'h0) st_d.tb = 1'b0;
			end
		end

		// Parse a write line held in the command buffer.
		nw = '{st_q.cb[127:80], st_q.cb[71:64], st_q.cb[55:48],
			st_q.cb[39:32], st_q.cb[23:16]};
		wr_ok = st_q.cb[151:136] == KEY_WR && st_q.cb[135:128] == SP // RL6
			&& st_q.cb[79:72] == SP && st_q.cb[63:56] == SP
			&& st_q.cb[47:40] == SP && st_q.cb[31:24] == SP
			&& st_q.cb[15:0] == {CR, LF}; // RL7
		for (int i = 0; i < 6; i++) begin
			wr_ok = wr_ok && in_rng(nw.freq[8*i +: 8], 4'h0, 4'h9); // RL10
		end
		wr_ok = wr_ok && nw.freq >= FREQ_MIN && nw.freq <= FREQ_MAX // RL11
			&& in_rng(nw.rf, 4'h1, 4'h4) // RL12
			&& in_rng(nw.pw, 4'h0, 4'h9) // RL13
			&& in_rng(nw.ub, 4'h0, 4'h6) // RL14
			&& in_rng(nw.pa, 4'h0, 4'h2); // RL15

		// Phase machine.
		case (st_q.md)
			sleep_phase: begin
				st_d.md = resume_phase;
				st_d.tm = TW'(normal_cyc);
			end
			normal_phase: begin
				if (got) begin
					wr_en = (st_q.wp - st_q.rp) != PW'(1 << fifo_aw); // RL18
				end
				if (st_q.ar && air_rx_valid_in) begin
					txl = 1'b1; // RL17
					txb = air_rx_data_in;
				end
			end
			enter_phase: begin
				st_d.tm = st_q.tm - TW'(1);
				if (st_q.tm == TW'(0)) begin
					st_d.md = setting_phase; // RL2
					st_d.cn = 5'h0;
					st_d.cb = '0;
					st_d.pen = st_q.act;
				end
			end
			setting_phase: begin
				if (got) begin
					st_d.cb = {st_q.cb[143:0], gb};
					if (st_q.cn != 5'h1E) st_d.cn = st_q.cn + 5'h1;
				end
				if (got && gb == LF) begin
					// Only one line per entry; the rest is ignored.
					st_d.md = reply_phase; // RL5
					if (st_q.cn == RD_LEN - 5'h1
						&& {st_q.cb[23:0], gb} == CMD_RD) begin
						st_d.rbuf = {TAG_REPL, SP, body_of(st_q.act)}; // RL8
						st_d.rn = REP_LEN; // RL3
					end else if (st_q.cn == WR_LEN - 5'h1) begin
						st_d.cb = st_q.cb;
					end
				end
			end
			reply_phase: begin
				if (st_q.cn == WR_LEN && st_q.rn == 5'h0) begin
					st_d.cb = {st_q.cb[143:0], LF};
					st_d.cn = 5'h1F;
				end else if (st_q.cn == 5'h1F) begin
					st_d.cn = 5'h0;
					if (wr_ok) begin
						st_d.pen = nw; // RL9
						st_d.rbuf = {TAG_REPL, SP, body_of(nw)}; // RL9
						st_d.rn = REP_LEN; // RL3
					end // RL20
				end
				if (st_q.rn != 5'h0 && !st_q.tb) begin
					txl = 1'b1; // RL3
					txb = st_q.rbuf[167:160];
					st_d.rbuf = {st_q.rbuf[159:0], 8'h00};
					st_d.rn = st_q.rn - 5'h1;
				end
			end
			apply_phase: begin
				st_d.tm = st_q.tm - TW'(1);
				if (st_q.tm == TW'(0)) begin
					st_d.act = st_q.pen; // RL4
					st_d.md = resume_phase;
					st_d.tm = TW'(normal_cyc - apply_cyc);
				end
			end
			resume_phase: begin
				st_d.tm = st_q.tm - TW'(1);
				if (st_q.tm == TW'(0)) st_d.md = normal_phase; // RL1
			end
			default: st_d.md = resume_phase;
		endcase

		// Select edges move between work and setting.
		if (fall && st_q.md != sleep_phase) begin
			st_d.md = enter_phase;
			st_d.tm = TW'(setting_cyc);
			st_d.rb = 1'b0;
			st_d.tb = 1'b0;
			txl = 1'b0;
		end else if (rise && (st_q.md == enter_phase
			|| st_q.md == setting_phase || st_q.md == reply_phase)) begin
			st_d.md = apply_phase; // RL4
			st_d.tm = TW'(apply_cyc);
			st_d.rn = 5'h0;
			st_d.tb = 1'b0;
			st_d.rb = 1'b0;
			txl = 1'b0;
		end

		// Queue head moves to the radio when the radio takes a byte.
		if (!st_q.av || air_tx_ready_in) begin
			st_d.av = 1'b0;
			if (st_q.wp != st_q.rp) begin
				st_d.av = 1'b1;
				st_d.ad = mem[st_q.rp[fifo_aw-1:0]];
				st_d.rp = st_q.rp + PW'(1);
			end
		end
		if (wr_en) st_d.wp = st_q.wp + PW'(1);

		if (txl) begin
			st_d.tb = 1'b1;
			st_d.tc = dv - 18'h1;
			st_d.ti = nbits;
			st_d.tsh = (np != 2'h0) ? {1'b1, ^txb ^ np[1], txb, 1'b0}
				: {2'b11, txb, 1'b0};
		end

		// Sleep holds everything but the radio queue idle until enable returns.
		if (!st_d.ef) begin
			st_d.md = sleep_phase; // RL16
			st_d.rb = 1'b0;
			st_d.tb = 1'b0;
			st_d.rn = 5'h0;
		end

		// Radio may deliver only while the serial side is quiet.
		st_d.ar = st_d.md == normal_phase && !st_d.tb && !st_d.rb
			&& st_d.wp == st_d.rp && !st_d.av; // RL17
		st_d.txd = st_d.tb ? st_d.tsh[0] : 1'b1;
	end

	// ************************************************
	// Registers
	// ************************************************
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			st_q <= '0;
			st_q.md <= resume_phase;
			st_q.tm <= TW'(normal_cyc);
			st_q.ss <= 3'b111;
			st_q.rs <= 3'b111;
			st_q.es <= 3'b111;
			st_q.sf <= 1'b1;
			st_q.rf <= 1'b1;
			st_q.ef <= 1'b1;
			st_q.txd <= 1'b1;
			st_q.act <= PRM_RST;
			st_q.pen <= PRM_RST;
		end else begin
			st_q <= st_d;
		end
	end

	// Serial bytes waiting for the radio.
	always_ff @(posedge clk_in) begin
		if (wr_en) mem[st_q.wp[fifo_aw-1:0]] <= gb; // RL18
	end

	// Outputs straight from the state register.
	assign link.up_line     = st_q.txd;
	assign air_tx_data_out  = st_q.ad;
	assign air_tx_valid_out = st_q.av;
	assign air_rx_ready_out = st_q.ar;
	assign phase_out        = st_q.md;
	assign params_out       = st_q.act;
endmodule
`default_nettype wire

// ==== hdl/radio_cfg_host.sv ====
/*
 * Host terminal end: runs one select-pin configuration sequence per
 * software order and reports the module's reply in registers.
 * Assumes software on a plain strobe port; one clock.
 */
`timescale 1ns/1ps
`default_nettype none
module radio_cfg_host import radio_cfg_pkg::*; #(
	parameter int unsigned clk_hz      = CLK_HZ,
	parameter int unsigned normal_cyc  = NORMAL_CYC,
	parameter int unsigned setting_cyc = SETTING_CYC,
	parameter int unsigned reply_cyc   = REPLY_CYC
) (
	// Clock and reset.
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	// Software port.
	input  wire logic [4:0]  addr_in,
	input  wire logic [31:0] wdata_in,
	input  wire logic        wr_in,
	input  wire logic        rd_in,
	output var  logic [31:0] rdata_out,
	// Pins toward the module.
	radio_link_if.host_end   link
);
	localparam logic [15:0] HDIV = 16'(clk_hz / SETUP_BAUD);

	typedef enum logic [2:0] {
		h_idle  = 3'b000,
		h_lower = 3'b001,
		h_send  = 3'b010,
		h_wait  = 3'b011,
		h_raise = 3'b100
	} hstate_t;

	typedef struct packed {
		hstate_t       md;
		logic [2:0]    rs;
		logic          rf;
		logic [TW-1:0] tm;
		logic          rb;
		logic [15:0]   rc;
		logic [3:0]    ri;
		logic [9:0]    rsh;
		logic          tb;
		logic [15:0]   tc;
		logic [3:0]    ti;
		logic [9:0]    tsh;
		logic          set, txd, en, wrq;
		logic          busy, done, ok, rerr;
		logic [23:0]   freq, rfreq;
		logic [15:0]   codes, rcodes;
		logic [151:0]  cb;
		logic [4:0]    cn;
		logic [167:0]  rbuf;
		logic [31:0]   rdata;
	} host_t;

	host_t st_q, st_d;
	prm_t        cmd;
	logic [167:0] nb;
	logic        bad;

	// ************************************************
	// Next-state logic
	// ************************************************
	always_comb begin
		st_d = st_q;
		st_d.rdata = 32'h0;
		nb = {st_q.rbuf[159:0], st_q.rsh[8:1]};
		// Ordered fields turned to ASCII digits.
		for (int i = 0; i < 6; i++) begin
			cmd.freq[8*i +: 8] = {DIG_HI, st_q.freq[4*i +: 4]}; // RL10
		end
		cmd.rf = {DIG_HI, st_q.codes[3:0]};
		cmd.pw = {DIG_HI, st_q.codes[7:4]};
		cmd.ub = {DIG_HI, st_q.codes[11:8]};
		cmd.pa = {DIG_HI, st_q.codes[15:12]};
		bad = st_q.freq < BCD_MIN || st_q.freq > BCD_MAX // RL11
			|| !in_rng(cmd.rf, 4'h1, 4'h4) || !in_rng(cmd.pw, 4'h0, 4'h9)
			|| !in_rng(cmd.ub, 4'h0, 4'h6) || !in_rng(cmd.pa, 4'h0, 4'h2);
		for (int i = 0; i < 6; i++) begin
			bad = bad || st_q.freq[4*i +: 4] > 4'h9;
		end

		// Receiver from the module, fixed 9600 8N1, three-stage sync.
		st_d.rs = {st_q.rs[1:0], link.up_line};
		if (st_q.rs[1] == st_q.rs[2]) st_d.rf = st_q.rs[2];
		if (st_q.rb) begin
			if (st_q.rc != 16'h0) begin
				st_d.rc = st_q.rc - 16'h1;
			end else begin
				st_d.rc = HDIV - 16'h1;
				st_d.rsh[st_q.ri] = st_q.rf;
				st_d.ri = st_q.ri + 4'h1;
				if (st_q.ri == 4'h0 && st_q.rf) st_d.rb = 1'b0;
				else if (st_q.ri == 4'h9) st_d.rb = 1'b0;
			end
		end else if (!st_q.rf) begin
			st_d.rb = 1'b1;
			st_d.ri = 4'h0;
			st_d.rc = {1'b0, HDIV[15:1]};
		end

		// Transmitter to the module.
		if (st_q.tb) begin
			if (st_q.tc != 16'h0) begin
				st_d.tc = st_q.tc - 16'h1;
			end else begin
				st_d.tc = HDIV - 16'h1;
				st_d.tsh = {1'b1, st_q.tsh[9:1]};
				st_d.ti = st_q.ti - 4'h1;
				if (st_q.ti == 4'h0) st_d.tb = 1'b0;
			end
		end

		case (st_q.md)
			h_idle: begin
				if (wr_in && addr_in == A_CTRL && wdata_in[0]) begin
					if (wdata_in[1] && bad) begin
						st_d.rerr = 1'b1; // RL11
					end else begin
						st_d.wrq = wdata_in[1];
						st_d.busy = 1'b1;
						st_d.done = 1'b0;
						st_d.ok = 1'b0;
						st_d.rerr = 1'b0;
						st_d.set = 1'b0;
						st_d.md = h_lower;
						st_d.tm = TW'(2 * setting_cyc);
						st_d.cb = wdata_in[1]
							? {KEY_WR, SP, body_of(cmd)} // RL9
							: {CMD_RD, 120'h0};
						st_d.cn = wdata_in[1] ? WR_LEN : RD_LEN; // RL5
					end
				end
			end
			h_lower: begin
				st_d.tm = st_q.tm - TW'(1);
				if (st_q.tm == TW'(0)) st_d.md = h_send; // RL2
			end
			h_send: begin
				if (!st_q.tb && st_q.cn != 5'h0) begin
					st_d.tb = 1'b1;
					st_d.tc = HDIV - 16'h1;
					st_d.ti = 4'h9;
					st_d.tsh = {1'b1, st_q.cb[151:144], 1'b0};
					st_d.cb = {st_q.cb[143:0], 8'h00};
					st_d.cn = st_q.cn - 5'h1;
				end else if (!st_q.tb) begin
					st_d.md = h_wait;
					st_d.tm = TW'(reply_cyc);
				end
			end
			h_wait: begin
				st_d.tm = st_q.tm - TW'(1);
				if (st_q.rb && st_q.rc == 16'h0 && st_q.ri == 4'h9
					&& st_q.rf) begin
					st_d.rbuf = nb;
					if (nb[7:0] == LF) begin
						st_d.ok = nb[167:128] == {TAG_REPL, SP} // RL8
							&& (!st_q.wrq || nb[127:0] == body_of(cmd));
						for (int i = 0; i < 6; i++) begin
							st_d.rfreq[4*i +: 4] = nb[80+8*i +: 4];
						end
						st_d.rcodes = {nb[19:16], nb[35:32], nb[51:48],
							nb[67:64]};
						st_d.md = h_raise; // RL4
						st_d.set = 1'b1;
						st_d.tm = TW'(normal_cyc);
					end
				end else if (st_q.tm == TW'(0)) begin
					st_d.md = h_raise;
					st_d.set = 1'b1;
					st_d.tm = TW'(normal_cyc);
				end
			end
			h_raise: begin
				st_d.tm = st_q.tm - TW'(1);
				if (st_q.tm == TW'(0)) begin
					st_d.md = h_idle; // RL1
					st_d.busy = 1'b0;
					st_d.done = 1'b1;
				end
			end
			default: st_d.md = h_idle;
		endcase

		// Software writes and reads.
		if (wr_in && addr_in == A_CTRL) st_d.en = wdata_in[2]; // RL16
		if (wr_in && addr_in == A_FREQ && !st_q.busy) begin
			st_d.freq = wdata_in[23:0];
		end
		if (wr_in && addr_in == A_CODES && !st_q.busy) begin
			st_d.codes = wdata_in[15:0];
		end
		if (rd_in) begin
			case (addr_in)
				A_CTRL:   st_d.rdata = {29'h0, st_q.en, st_q.wrq, 1'b0};
				A_FREQ:   st_d.rdata = {8'h00, st_q.freq};
				A_CODES:  st_d.rdata = {16'h0000, st_q.codes};
				A_STAT:   st_d.rdata = {28'h0, st_q.rerr, st_q.ok,
					st_q.done, st_q.busy};
				A_RFREQ:  st_d.rdata = {8'h00, st_q.rfreq};
				A_RCODES: st_d.rdata = {16'h0000, st_q.rcodes};
				default:  st_d.rdata = 32'h0;
			endcase
		end
		st_d.txd = st_d.tb ? st_d.tsh[0] : 1'b1;
	end

	// ************************************************
	// Registers
	// ************************************************
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			st_q <= '0;
			st_q.rs <= 3'b111;
			st_q.rf <= 1'b1;
			st_q.set <= 1'b1;
			st_q.txd <= 1'b1;
			st_q.en <= 1'b1;
			st_q.freq <= 24'h434000;
			st_q.codes <= 16'h0393;
		end else begin
			st_q <= st_d;
		end
	end

	// Pins and read data straight from the state register.
	assign link.set_pin   = st_q.set;
	assign link.en_pin    = st_q.en;
	assign link.down_line = st_q.txd;
	assign rdata_out      = st_q.rdata;
endmodule
`default_nettype wire

// ==== test/radio_link_checker.sv ====
/*
 * Concurrent checks on the host-to-module link and the module status.
 * Assumes one clock; the bench places it beside the link it watches.
 */
`timescale 1ns/1ps
`default_nettype none
module radio_link_checker import radio_cfg_pkg::*; #(
	parameter int unsigned setting_cyc = 200,
	parameter int unsigned normal_cyc  = 600
) (
	// Clock and reset.
	input wire logic   clk_in,
	input wire logic   rst_in,
	// Link pins.
	input wire logic   set_pin,
	input wire logic   en_pin,
	input wire logic   down_line,
	input wire logic   up_line,
	// Device status.
	input wire phase_t phase_out,
	input wire prm_t   params_out
);
	// ************************************************
	// Link checks
	// ************************************************
	localparam int S_MAX = setting_cyc + 16;
	localparam int N_MAX = normal_cyc + 16;

	// Every check runs on the one clock and rests while reset is high.
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	a_setting_entry: assert property ($fell(set_pin) |->
		##[1:S_MAX] phase_out == setting_phase)
		else $error("setting mode not reached after select fell");
	a_setting_needs_low: assert property (
		phase_out == setting_phase |-> !$past(set_pin, 8))
		else $error("setting mode without select low");
	a_normal_return: assert property ($rose(set_pin) |->
		##[1:N_MAX] phase_out == normal_phase)
		else $error("normal mode not reached after select rose");
	a_enable_sleep: assert property ($fell(en_pin) |->
		##[1:12] phase_out == sleep_phase)
		else $error("module did not sleep with enable low");
	a_setting_silent: assert property (
		phase_out == setting_phase |-> up_line)
		else $error("module talked before a valid command");
	a_host_quiet_reply: assert property (
		phase_out == reply_phase |-> down_line)
		else $error("host sent while the reply was due");
	a_down_idle_normal: assert property (set_pin |-> down_line)
		else $error("host serial line busy outside setting");
	a_params_hold: assert property (
		$changed(params_out) |-> set_pin && $past(set_pin))
		else $error("parameters changed while select low");
endmodule
`default_nettype wire

// ==== test/radio_module_config_port_tb.sv ====
/*
 * Self-checking bench: host end and module end joined by the link.
 * Assumes shortened counts: 20 clocks a bit, short phase waits.
 */
`timescale 1ns/1ps
`default_nettype none
module radio_module_config_port_tb import radio_cfg_pkg::*; #(
	parameter int unsigned hz = 192000, n_cyc = 600, s_cyc = 200, a_cyc = 100);
	// ************************************************
	// Signals and design
	// ************************************************
	logic        clk_in      = 1'b0;
	logic        rst_in      = 1'b1;
	logic [4:0]  addr        = 5'h00;
	logic [31:0] wdata       = 32'h0;
	logic        wr_s        = 1'b0;
	logic        rd_s        = 1'b0;
	logic [31:0] rdata;
	logic [7:0]  rx_byte     = 8'h00;
	logic        rx_valid    = 1'b0;
	logic        rx_ready;
	logic        tx_ready    = 1'b1;
	logic [7:0]  tx_byte;
	logic        tx_valid;
	phase_t      phase;
	prm_t        params;
	logic [23:0] cur_f       = 24'h434000;
	logic [15:0] cur_c       = 16'h0393;
	int          fail_count  = 0;
	int          comparisons = 0;

	// Clock of 4 ns.
	always #2 clk_in = ~clk_in;

	radio_link_if link ();
	radio_cfg_host #(.clk_hz(hz), .normal_cyc(n_cyc),
		.setting_cyc(s_cyc)) u_radio_cfg_host (
		.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr),
		.wdata_in(wdata), .wr_in(wr_s), .rd_in(rd_s),
		.rdata_out(rdata), .link(link));
	radio_cfg_dev #(.clk_hz(hz), .normal_cyc(n_cyc),
		.setting_cyc(s_cyc), .apply_cyc(a_cyc)) u_radio_cfg_dev (
		.clk_in(clk_in), .rst_in(rst_in), .link(link),
		.air_tx_data_out(tx_byte), .air_tx_valid_out(tx_valid),
		.air_tx_ready_in(tx_ready), .air_rx_data_in(rx_byte),
		.air_rx_valid_in(rx_valid), .air_rx_ready_out(rx_ready),
		.phase_out(phase), .params_out(params));
	radio_link_checker #(.setting_cyc(s_cyc), .normal_cyc(n_cyc))
		u_radio_link_checker (.clk_in(clk_in), .rst_in(rst_in),
		.set_pin(link.set_pin), .en_pin(link.en_pin),
		.down_line(link.down_line), .up_line(link.up_line),
		.phase_out(phase), .params_out(params));

	// ************************************************
	// Tasks and expectations
	// ************************************************
	// Compare tasks count every comparison and report a mismatch.
	task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chkp(input prm_t got, input prm_t exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Decimal kilohertz to six packed digits.
	function automatic logic [23:0] bcd(input int unsigned n);
		for (int i = 0; i < 6; i++) begin
			bcd[i*4 +: 4] = 4'(n % 10);
			n = n / 10;
		end
	endfunction

	// Digits and codes to the ASCII parameter set.
	function automatic prm_t exp_prm(input logic [23:0] f,
		input logic [15:0] c);
		for (int i = 0; i < 6; i++)
			exp_prm.freq[i*8 +: 8] = {4'h3, f[i*4 +: 4]};
		exp_prm.rf = {4'h3, c[3:0]};
		exp_prm.pw = {4'h3, c[7:4]};
		exp_prm.ub = {4'h3, c[11:8]};
		exp_prm.pa = {4'h3, c[15:12]};
	endfunction

	// Software port cycles: one-cycle strobes, read data a cycle later.
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge clk_in);
		addr  <= a;
		wdata <= d;
		wr_s  <= 1'b1;
		@(posedge clk_in);
		wr_s  <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, output logic [31:0] d);
		@(posedge clk_in);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk_in);
		rd_s <= 1'b0;
		@(negedge clk_in);
		d = rdata;
	endtask

	task automatic wait_normal();
		for (int n = 0; n < 4000 && phase !== normal_phase; n++)
			@(negedge clk_in);
	endtask

	// One select-pin sequence, then reply and applied values checked.
	task automatic run_cfg(input logic w, input logic [23:0] f,
		input logic [15:0] c);
		logic [31:0] st = 32'h0;
		if (w) begin
			wr(A_FREQ, {8'h00, f});
			wr(A_CODES, {16'h0000, c});
			cur_f = f;
			cur_c = c;
		end
		wr(A_CTRL, {29'h0, 1'b1, w, 1'b1});
		for (int n = 0; n < 20000 && st[1] !== 1'b1; n++)
			rd(A_STAT, st);
		chk32(st, 32'h6);
		rd(A_RFREQ, st);
		chk32(st, {8'h00, cur_f});
		rd(A_RCODES, st);
		chk32(st, {16'h0000, cur_c});
		wait_normal();
		chkp(params, exp_prm(cur_f, cur_c));
	endtask

	task automatic final_report();
		$display("mismatches=%0d comparisons=%0d", fail_count, comparisons);
		if (fail_count == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// ************************************************
	// Test sequence
	// ************************************************
	// Reads, writes with corner and random values, refusals, sleep, air.
	initial begin
		int unsigned f;
		logic [15:0] c;
		logic [31:0] st;
		logic [15:0] cw [3] = '{16'h2601, 16'h1094, 16'h0352};
		logic [23:0] bf [3] = '{24'h455001, 24'h417999, 24'h434000};
		logic [15:0] bc [3] = '{16'h0393, 16'h0393, 16'h3393};
		void'($urandom(32'h1E1FCF5D));
		repeat (10) @(posedge clk_in);
		rst_in <= 1'b0;
		wait_normal();
		run_cfg(1'b0, cur_f, cur_c);
		for (int i = 0; i < 4; i++) begin
			f = (i == 0) ? 418000 : (i == 1) ? 455000 :
				418000 + $urandom % 37001;
			c = (i == 3) ? {4'($urandom % 3), 4'($urandom % 7),
				4'($urandom % 10), 4'(1 + $urandom % 4)} : cw[i];
			run_cfg(1'b1, bcd(f), c);
		end
		for (int i = 0; i < 3; i++) begin
			wr(A_FREQ, {8'h00, bf[i]});
			wr(A_CODES, {16'h0000, bc[i]});
			wr(A_CTRL, 32'h7);
			rd(A_STAT, st);
			chk32(st & 32'h9, 32'h8);
			chkp(params, exp_prm(cur_f, cur_c));
		end
		wr(A_CTRL, 32'h0);
		repeat (20) @(negedge clk_in);
		chk32({29'h0, phase}, {29'h0, sleep_phase});
		wr(A_CTRL, 32'h4);
		wait_normal();
		@(posedge clk_in);
		rx_byte  <= 8'($urandom);
		rx_valid <= 1'b1;
		for (int n = 0; n < 50 && rx_ready !== 1'b1; n++)
			@(negedge clk_in);
		@(posedge clk_in);
		rx_valid <= 1'b0;
		@(negedge clk_in);
		chk32({31'h0, link.up_line}, 32'h0);
		chk32({31'h0, tx_valid}, 32'h0);
		run_cfg(1'b0, cur_f, cur_c);
		final_report();
	end

	// Watchdog well beyond the expected run length.
	initial begin
		repeat (100000) @(posedge clk_in);
		fail_count++;
		final_report();
	end
endmodule
`default_nettype wire
